// file: hw/sldr_strap_loader.sv
// strap sampling, per-port default registers and avalon-mm slave
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module sldr_strap_loader
  import sldr_pkg::*;
#(
  parameter int P = NUM_PORTS
)
(
  // clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_resetn,
  // strap pins
  input  wire logic                        i_xover_sel_pin,
  input  wire logic                        i_auto_crossover_enable_strap,
  input  wire logic [CFG_WIDTH-1:0]        i_global_cfg_strap,
  input  wire logic                        i_hw_control_mode,
  // shared pin output side (receive error of port 0)
  input  wire logic                        i_rx_error0,
  output logic                             o_xover_pin_out,
  output logic                             o_xover_pin_oe,
  // per-port effective settings
  output logic [P-1:0]                     o_auto_xover_on,
  output logic [P-1:0]                     o_force_xover,
  output logic [P-1:0][CFG_WIDTH-1:0]      o_port_cfg,
  // avalon-mm slave
  input  wire logic [ADDR_WIDTH-1:0]       i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [DATA_WIDTH-1:0]       i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic [DATA_WIDTH-1:0]            o_avs_readdata,
  output logic                             o_avs_waitrequest
);

  // ============================================================
  // state
  typedef struct packed {
    sldr_phase_e                      phase;
    logic                             ack;
    logic [DATA_WIDTH-1:0]            rdata;
    logic                             rx_error;
    sldr_port_s                       strap;
    sldr_port_s [P-1:0]               port;
    logic [P-1:0]                     auto_on;
    logic [P-1:0]                     force_xover;
    logic [P-1:0][CFG_WIDTH-1:0]      cfg;
  } sldr_state_s;

  sldr_state_s state_q;
  sldr_state_s state_d;

  logic bus_req;

  assign bus_req = i_avs_read | i_avs_write;

  // ============================================================
  // next state
  always_comb
  begin
    logic [DATA_WIDTH-1:0] rd_mux;
    rd_mux = '0;
    state_d = state_q;
    state_d.ack = 1'b0;
    state_d.rx_error = i_rx_error0;
    if (i_avs_address == SLDR_STATUS_OFS)
    begin
      rd_mux[SLDR_FIELD_WIDTH-1:0] = state_q.strap;
      rd_mux[SLDR_DONE_BIT] = (state_q.phase == SLDR_RUN);
    end
    for (int p = 0; p < P; p++)
    begin
      if (i_avs_address == SLDR_PORT_BASE_OFS + 8'(p) * SLDR_PORT_STRIDE)
      begin
        rd_mux[SLDR_FIELD_WIDTH-1:0] = state_q.port[p];
      end
    end
    unique case (state_q.phase)
      SLDR_LOAD:
      begin
        // every port defaults from the held strap levels
        for (int p = 0; p < P; p++)
        begin
          state_d.port[p] = state_q.strap;
          state_d.port[p].auto_xover = state_q.strap.auto_xover;
          state_d.port[p].cfg = state_q.strap.cfg;
        end
        state_d.phase = SLDR_RUN;
      end
      SLDR_RUN:
      begin
        if (bus_req && !state_q.ack)
        begin
          state_d.ack = 1'b1;
          // read data only changes on a read, writes leave it standing
          if (i_avs_read)
          begin
            state_d.rdata = rd_mux;
          end
        end
        else if (state_q.ack && i_avs_write && i_avs_byteenable[0])
        begin
          for (int p = 0; p < P; p++)
          begin
            if (i_avs_address == SLDR_PORT_BASE_OFS + 8'(p) * SLDR_PORT_STRIDE)
            begin
              state_d.port[p] = sldr_port_s'(i_avs_writedata[SLDR_FIELD_WIDTH-1:0]);
            end
          end
        end
      end
    endcase
    for (int p = 0; p < P; p++)
    begin
      state_d.auto_on[p] = state_q.port[p].auto_xover;
      // forced mode only when auto-crossover is off
      state_d.force_xover[p] = !state_q.port[p].auto_xover && state_q.port[p].xover_sel;
      state_d.cfg[p] = i_hw_control_mode ? state_q.strap.cfg : state_q.port[p].cfg;
    end
    if (!i_resetn)
    begin
      state_d = '0;
      state_d.phase = SLDR_LOAD;
      // holding flops track the pins while reset is low and freeze at release
      state_d.strap.xover_sel = i_xover_sel_pin;
      state_d.strap.auto_xover = i_auto_crossover_enable_strap;
      state_d.strap.cfg = i_global_cfg_strap;
    end
  end

  always_ff @(posedge i_clock)
  begin
    state_q <= state_d;
  end

  // ============================================================
  // outputs
  // pin released only once the strap is safely held
  assign o_xover_pin_oe    = i_resetn && (state_q.phase == SLDR_RUN);
  assign o_xover_pin_out   = state_q.rx_error;
  assign o_auto_xover_on   = state_q.auto_on;
  assign o_force_xover     = state_q.force_xover;
  assign o_port_cfg        = state_q.cfg;
  assign o_avs_readdata    = state_q.rdata;
  assign o_avs_waitrequest = (state_q.phase == SLDR_LOAD) || !state_q.ack;

  // ============================================================
  // assertions
  default clocking sldr_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  a_load_xover_sel: assert property (
    (i_resetn && state_q.phase == SLDR_LOAD) |=>
      (state_q.port[0].xover_sel == $past(state_q.strap.xover_sel)) &&
      (state_q.port[P-1].xover_sel == $past(state_q.strap.xover_sel)))
    else $error("crossover select default not loaded from strap");

  a_write_override: assert property (
    (!o_avs_waitrequest && i_avs_write && i_avs_byteenable[0] &&
     i_avs_address == SLDR_PORT_BASE_OFS) |=>
      (state_q.port[0] == $past(i_avs_writedata[SLDR_FIELD_WIDTH-1:0])))
    else $error("port register write did not take effect");

  a_auto_ignores_sel: assert property (
    (state_q.phase == SLDR_RUN && state_q.port[0].auto_xover) |=>
      (o_auto_xover_on[0] && !o_force_xover[0]))
    else $error("crossover select honoured while auto-crossover on");

  a_forced_mode: assert property (
    (state_q.phase == SLDR_RUN && !state_q.port[P-1].auto_xover) |=>
      (o_force_xover[P-1] == $past(state_q.port[P-1].xover_sel)))
    else $error("forced crossover mode does not follow select bit");

  a_pin_released: assert property (
    disable iff (1'b0)
    (!i_resetn) |-> !o_xover_pin_oe ##1 !o_xover_pin_oe)
    else $error("shared pin driven during or just after reset");

  a_load_global_cfg: assert property (
    (i_resetn && state_q.phase == SLDR_LOAD) |=>
      (state_q.port[P-1].cfg == $past(state_q.strap.cfg)))
    else $error("global config default not loaded from straps");

  a_pin_control_cfg: assert property (
    (i_hw_control_mode && state_q.phase == SLDR_RUN) |=>
      (o_port_cfg[0] == state_q.strap.cfg && o_port_cfg[P-1] == state_q.strap.cfg))
    else $error("pin-controlled config not taken from straps");

  a_load_auto_xover: assert property (
    (i_resetn && state_q.phase == SLDR_LOAD) |=> ##1
      (o_auto_xover_on[0] == $past(state_q.strap.auto_xover, 2)))
    else $error("auto-crossover default not loaded from strap");

  a_straps_held: assert property (
    (state_q.phase == SLDR_RUN) [*2] |-> $stable(state_q.strap))
    else $error("held strap levels changed after reset");

  a_straps_track: assert property (
    disable iff (1'b0)
    (!i_resetn) |=>
      (state_q.strap.xover_sel == $past(i_xover_sel_pin) &&
       state_q.strap.auto_xover == $past(i_auto_crossover_enable_strap) &&
       state_q.strap.cfg == $past(i_global_cfg_strap)))
    else $error("holding flops did not follow the straps during reset");

  a_reset_outputs: assert property (
    disable iff (1'b0)
    (!i_resetn) |=>
      (o_auto_xover_on == '0 && o_force_xover == '0 && o_port_cfg == '0 && o_avs_waitrequest))
    else $error("outputs not cleared by reset");

  a_load_one_cycle: assert property (
    (i_resetn && state_q.phase == SLDR_LOAD) |=>
      (state_q.phase == SLDR_RUN))
    else $error("default load did not finish in one cycle");

  a_pin_driven_run: assert property (
    (i_resetn && state_q.phase == SLDR_RUN) |->
      o_xover_pin_oe)
    else $error("shared pin not reused as output after load");

  a_pin_out_follows: assert property (
    i_resetn |=>
      (o_xover_pin_out == $past(i_rx_error0)))
    else $error("shared pin output does not follow receive error");

  // ============================================================
  // register bus checks
  a_wait_one_cycle: assert property (
    (i_resetn && bus_req && state_q.phase == SLDR_RUN && !state_q.ack) |=>
      !o_avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  a_ack_one_cycle: assert property (
    !o_avs_waitrequest |=>
      o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  a_status_read: assert property (
    (!o_avs_waitrequest && i_avs_read && i_avs_address == SLDR_STATUS_OFS) |->
      (o_avs_readdata[SLDR_FIELD_WIDTH-1:0] == state_q.strap &&
       o_avs_readdata[SLDR_DONE_BIT]))
    else $error("status read does not show held straps and load done");

  a_read_upper_zero: assert property (
    (!o_avs_waitrequest && i_avs_read) |->
      (o_avs_readdata[DATA_WIDTH-1:SLDR_DONE_BIT+1] == '0))
    else $error("unused read data bits not zero");

  a_readdata_held: assert property (
    (i_resetn && !i_avs_read) |=>
      $stable(o_avs_readdata))
    else $error("read data changed without a read");

  a_write_ignored_be: assert property (
    (!o_avs_waitrequest && i_avs_write && !i_avs_byteenable[0]) |=>
      $stable(state_q.port))
    else $error("write without byte lane 0 changed a port register");

  // ============================================================
  // per-port checks, every port and not only the end ones
  for (genvar g = 0; g < P; g++)
  begin : g_port_chk
    localparam logic [7:0] OWN_OFS = SLDR_PORT_BASE_OFS + 8'(g) * SLDR_PORT_STRIDE;

    a_port_load: assert property (
      (i_resetn && state_q.phase == SLDR_LOAD) |=>
        (state_q.port[g] == $past(state_q.strap)))
      else $error("port defaults not loaded from held straps");

    a_port_write: assert property (
      (!o_avs_waitrequest && i_avs_write && i_avs_byteenable[0] &&
       i_avs_address == OWN_OFS) |=>
        (state_q.port[g] == $past(i_avs_writedata[SLDR_FIELD_WIDTH-1:0])))
      else $error("port register write lost");

    a_port_hold: assert property (
      (i_resetn && state_q.phase == SLDR_RUN &&
       !(!o_avs_waitrequest && i_avs_write && i_avs_byteenable[0] &&
         i_avs_address == OWN_OFS)) |=>
        $stable(state_q.port[g]))
      else $error("port register changed without a write");

    a_port_read: assert property (
      (!o_avs_waitrequest && i_avs_read && i_avs_address == OWN_OFS) |->
        (o_avs_readdata[SLDR_FIELD_WIDTH-1:0] == state_q.port[g] &&
         o_avs_readdata[DATA_WIDTH-1:SLDR_FIELD_WIDTH] == '0))
      else $error("port register read returned a wrong value");

    a_port_auto_out: assert property (
      i_resetn |=>
        (o_auto_xover_on[g] == $past(state_q.port[g].auto_xover)))
      else $error("auto-crossover output does not follow its bit");

    a_port_auto_wins: assert property (
      (i_resetn && state_q.port[g].auto_xover) |=>
        !o_force_xover[g])
      else $error("forced crossover while auto-crossover on");

    a_port_force_out: assert property (
      i_resetn |=>
        (o_force_xover[g] ==
         $past(state_q.port[g].xover_sel && !state_q.port[g].auto_xover)))
      else $error("forced crossover does not follow select level");

    a_port_cfg_out: assert property (
      i_resetn |=>
        (o_port_cfg[g] == ($past(i_hw_control_mode) ? $past(state_q.strap.cfg) :
                                                       $past(state_q.port[g].cfg))))
      else $error("port config output from the wrong source");
  end

endmodule : sldr_strap_loader

// file: hw/sldr_pkg.sv
// constants, types and field layout of the strap default loader
// ============================================================
// Operation
// - at reset, crossover select strap becomes every port's crossover select default
// - after reset, strap-loaded bits stay readable and writable; writes override defaults
// - auto-crossover enable active means the crossover select level is ignored
// - auto-crossover off forces all ports: high selects crossover, low straight-through
// - shared receive-error output is three-stated during reset so the strap is sampled
// - at reset, three global configuration straps load every port's global config default
// - in pin-controlled operation, all ports take options from the global config straps
// - auto-crossover enable strap defaults every port's auto-crossover bit
package sldr_pkg;

  // ============================================================
  // sizes
  localparam int NUM_PORTS  = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int CFG_WIDTH  = 3;

  // ============================================================
  // register map (byte addresses)
  localparam logic [7:0] SLDR_STATUS_OFS    = 8'h00;
  localparam logic [7:0] SLDR_PORT_BASE_OFS = 8'h10;
  localparam logic [7:0] SLDR_PORT_STRIDE   = 8'h04;

  // ============================================================
  // field positions
  localparam int SLDR_XOVER_SEL_BIT = 0;
  localparam int SLDR_AUTO_XOVER_BIT = 1;
  localparam int SLDR_CFG_LSB       = 2;
  localparam int SLDR_FIELD_WIDTH   = 5;
  localparam int SLDR_DONE_BIT      = 8;

  // ============================================================
  // types
  typedef enum logic [0:0] {
    SLDR_LOAD,
    SLDR_RUN
  } sldr_phase_e;

  // per-port strap-defaulted bits; also the layout of the strap holding flops
  typedef struct packed {
    logic [CFG_WIDTH-1:0] cfg;
    logic                 auto_xover;
    logic                 xover_sel;
  } sldr_port_s;

  localparam sldr_port_s SLDR_PORT_RESET = '0;

endpackage : sldr_pkg

// file: verification/sldr_strap_board.sv
// board strap wiring on the shared crossover select pin
`timescale 1ns/100ps
module sldr_strap_board
(
  // board option
  input  wire logic i_pullup,
  // device drive
  input  wire logic i_dev_out,
  input  wire logic i_dev_oe,
  // resolved pin
  output logic      o_pin
);
  // external pull-up gives 1, otherwise the internal pull-down gives 0
  assign o_pin = i_dev_oe ? i_dev_out : i_pullup;
endmodule : sldr_strap_board

// file: verification/strap_default_loader_tb.sv
// self-checking bench of the strap default loader
`timescale 1ns/100ps
module strap_default_loader_tb;
  import sldr_pkg::*;
  logic                  clk = 0, rstn = 0, pull = 1, auto_en = 0, hw = 0, rxe = 0;
  logic                  rd = 0, wr = 0;
  logic [2:0]            cfg = 3'h5;
  logic [7:0]            adr = 8'h00;
  logic [3:0]            be = 4'h1;
  logic [31:0]           wd = 32'h0, r;
  wire                   pin, pout, poe, wreq;
  wire  [7:0]            aon, fx;
  wire  [7:0][2:0]       pcfg;
  wire  [31:0]           rdata;
  int                    n_mismatch = 0, checks_done = 0;
  always #5 clk = ~clk;
  sldr_strap_loader uut (.i_clock(clk), .i_resetn(rstn), .i_xover_sel_pin(pin),
    .i_auto_crossover_enable_strap(auto_en), .i_global_cfg_strap(cfg), .i_hw_control_mode(hw),
    .i_rx_error0(rxe), .o_xover_pin_out(pout), .o_xover_pin_oe(poe), .o_auto_xover_on(aon),
    .o_force_xover(fx), .o_port_cfg(pcfg), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq));
  sldr_strap_board board (.i_pullup(pull), .i_dev_out(pout), .i_dev_oe(poe), .o_pin(pin));
  // ============================================================
  // helpers
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      stop_test();
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic rst(input logic p, input logic ae, input logic [2:0] c);
    rstn <= 1'b0;
    pull <= p;
    auto_en <= ae;
    cfg <= c;
    repeat (2) @(posedge clk);
    chk(32'(poe), 32'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  // ============================================================
  // scenarios
  task automatic t_defaults;
    rst(1'b1, 1'b0, 3'h5);
    for (int p = 0; p < 8; p++)
    begin
      acc(1'b0, 8'(8'h10 + 4 * p), 32'h0);
      chk(r, 32'h15);
    end
    acc(1'b0, 8'h00, 32'h0);
    chk(r, 32'h115);
    chk(32'(fx), 32'hff);
    chk(32'(aon), 32'h0);
  endtask : t_defaults
  task automatic t_pin_reuse;
    rxe <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'({poe, pin}), 32'h3);
    rxe <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(pin), 32'h0);
    acc(1'b0, 8'h00, 32'h0);
    chk(r, 32'h115);
  endtask : t_pin_reuse
  task automatic t_override;
    acc(1'b1, 8'h1c, 32'h2);
    acc(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'({aon[3], fx[3]}), 32'h2);
    chk(32'(pcfg[3]), 32'h0);
    hw <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pcfg[3]), 32'h5);
    hw <= 1'b0;
    acc(1'b0, 8'h80, 32'h0);
    chk(r, 32'h0);
    be <= 4'h0;
    acc(1'b1, 8'h10, 32'h0);
    be <= 4'h1;
    acc(1'b0, 8'h10, 32'h0);
    chk(r, 32'h15);
    acc(1'b1, 8'h10, 32'hffffffed);
    acc(1'b0, 8'h10, 32'h0);
    chk(r, 32'h0d);
    chk(32'({pcfg[0], aon[0], fx[0]}), 32'h0d);
  endtask : t_override
  task automatic t_auto_reset;
    rst(1'b0, 1'b1, 3'h2);
    acc(1'b0, 8'h24, 32'h0);
    chk(r, 32'h0a);
    chk(32'({aon, fx}), 32'hff00);
    acc(1'b0, 8'h00, 32'h0);
    chk(r, 32'h10a);
  endtask : t_auto_reset
  initial
  begin
    t_defaults();
    t_pin_reuse();
    t_override();
    t_auto_reset();
    stop_test();
  end
endmodule : strap_default_loader_tb
